// ===== rtl/remote_channel_comp_and_limit_regs.sv
// Register bank: remote noise-filter and beta enables, beta readbacks, local/remote-1 high limits.
// Assumes the serial interface decodes bytes into one-cycle reg_wr/reg_rd strobes on mclk.
//
// Contract
// - Per-channel noise filter enables, bits 1-3, reset clear.
// - Per-channel beta compensation enables, bits 1-3, off.
// - Channel 1 beta code read-only, bits 3:0.
// - Channels 2,3 beta codes read-only, separate registers.
// - Beta readback upper nibble reserved, reads zero.
// - Local high upper byte signed, resets 7Fh.
// - Local high lower byte fraction, low nibble zero.
// - Remote 1 high limit pair, same layout.
// - Format change never rewrites stored limits.
// - Extended range selects the reportable ceiling.
// - High flag set when temperature exceeds limit.
`timescale 1ns/10ps
`include "remote_comp_limit_regs.svh"

module remote_channel_comp_and_limit_regs
	import remote_comp_limit_pkg::*;
#(
	parameter int NUM_REMOTE = 3
)
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output      logic [7:0] reg_rdata,
	output      logic       reg_rvalid,
	input  wire logic       extended_range_select,
	input  wire logic [11:0] beta_code_in,
	input  wire logic [2:0] beta_code_valid,
	input  wire logic [15:0] local_temp,
	input  wire logic [15:0] remote1_temp,
	input  wire logic       result_valid,
	output      logic [2:0] noise_filter_on,
	output      logic [2:0] beta_comp_on,
	output      logic [15:0] temp_ceiling,
	output      logic       local_high_flag,
	output      logic       remote1_high_flag
);

	// ==========================================
	// Storage
	// ==========================================
	logic [2:0] noise_filter_enable;
	logic [2:0] beta_comp_enable;
	beta_code_t beta_readback [NUM_REMOTE];
	reg_byte_t  local_high_limit_upper;
	logic [3:0] local_high_limit_lower;
	reg_byte_t  remote1_high_limit_upper;
	logic [3:0] remote1_high_limit_lower;
	temp_word_t local_limit_word;
	temp_word_t remote1_limit_word;
	reg_byte_t  next_rdata;
	logic       local_over;
	logic       remote1_over;

	// ==========================================
	// Enable registers
	// ==========================================
	// Bit 0 and bits 7:4 are reserved, so only bits 3:1 are kept
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			noise_filter_enable <= `RST_CHANNEL_ENABLE;
			beta_comp_enable    <= `RST_CHANNEL_ENABLE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `OFS_NOISE_FILTER_ENABLE)
				noise_filter_enable <= reg_wdata[`CH_ENABLE_MSB:`CH_ENABLE_LSB];
			if (reg_addr == `OFS_BETA_COMP_ENABLE)
				beta_comp_enable <= reg_wdata[`CH_ENABLE_MSB:`CH_ENABLE_LSB];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			noise_filter_on <= 3'h0;
			beta_comp_on    <= 3'h0;
		end
		else
		begin
			noise_filter_on <= noise_filter_enable;
			beta_comp_on    <= beta_comp_enable;
		end
	end

	// ==========================================
	// Beta readbacks, loaded by the compensation engine only
	// ==========================================
	genvar ch;
	generate
		for (ch = 0; ch < NUM_REMOTE; ch++)
		begin : g_beta
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
					beta_readback[ch] <= `RST_BETA_READBACK;
				else if (beta_code_valid[ch])
					beta_readback[ch] <= beta_code_in[ch*4 +: 4];
			end
		end
	endgenerate

	// ==========================================
	// High limits
	// ==========================================
	// Stored as written; the format bit is deliberately not looked at here
	// Low nibble of each lower byte is not stored and always reads zero
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			local_high_limit_upper   <= `RST_LIMIT_UPPER;
			local_high_limit_lower   <= `RST_LIMIT_LOWER;
			remote1_high_limit_upper <= `RST_LIMIT_UPPER;
			remote1_high_limit_lower <= `RST_LIMIT_LOWER;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`OFS_LOCAL_HIGH_LIMIT_UPPER:   local_high_limit_upper <= reg_wdata;
				`OFS_LOCAL_HIGH_LIMIT_LOWER:
					local_high_limit_lower <= reg_wdata[7:`LOWER_FRAC_LSB];
				`OFS_REMOTE1_HIGH_LIMIT_UPPER: remote1_high_limit_upper <= reg_wdata;
				`OFS_REMOTE1_HIGH_LIMIT_LOWER:
					remote1_high_limit_lower <= reg_wdata[7:`LOWER_FRAC_LSB];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Comparison against conversion results
	// ==========================================
	// Encoding of extended values is the host's job; compare raw words
	assign local_limit_word   = {local_high_limit_upper, local_high_limit_lower, 4'h0};
	assign remote1_limit_word = {remote1_high_limit_upper, remote1_high_limit_lower, 4'h0};
	// Strictly greater: a result equal to its limit leaves the flag clear
	assign local_over         = $signed(local_temp) > $signed(local_limit_word);
	assign remote1_over       = $signed(remote1_temp) > $signed(remote1_limit_word);

	// ==========================================
	// Status flags
	// ==========================================
	// Level results of the latest compare, not sticky
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			local_high_flag <= 1'b0;
		else if (result_valid)
			local_high_flag <= local_over;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			remote1_high_flag <= 1'b0;
		else if (result_valid)
			remote1_high_flag <= remote1_over;
	end

	// ==========================================
	// Range ceiling
	// ==========================================
	// The format bit only moves this ceiling; stored limits keep their codes
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			temp_ceiling <= `RESULT_CEIL_NORMAL;
		else
			temp_ceiling <= extended_range_select ? `RESULT_CEIL_EXTENDED
			                                      : `RESULT_CEIL_NORMAL;
	end

	// ==========================================
	// Read port
	// ==========================================
	// Reserved and unmapped bits read as zero
	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			`OFS_NOISE_FILTER_ENABLE:      next_rdata = {4'h0, noise_filter_enable, 1'b0};
			`OFS_BETA_COMP_ENABLE:         next_rdata = {4'h0, beta_comp_enable, 1'b0};
			`OFS_BETA_READBACK_CH1:        next_rdata = {4'h0, beta_readback[0]};
			`OFS_BETA_READBACK_CH2:        next_rdata = {4'h0, beta_readback[1]};
			`OFS_BETA_READBACK_CH3:        next_rdata = {4'h0, beta_readback[2]};
			`OFS_LOCAL_HIGH_LIMIT_UPPER:   next_rdata = local_high_limit_upper;
			`OFS_LOCAL_HIGH_LIMIT_LOWER:   next_rdata = {local_high_limit_lower, 4'h0};
			`OFS_REMOTE1_HIGH_LIMIT_UPPER: next_rdata = remote1_high_limit_upper;
			`OFS_REMOTE1_HIGH_LIMIT_LOWER: next_rdata = {remote1_high_limit_lower, 4'h0};
			default:                       next_rdata = 8'h00;
		endcase
	end

	// Answer strobe: one cycle, right after the read strobe
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			reg_rvalid <= 1'b0;
		else
			reg_rvalid <= reg_rd;
	end

	// Data is held until the next read, so a slow host can still fetch it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

endmodule : remote_channel_comp_and_limit_regs

// ===== rtl/remote_comp_limit_regs.svh
// Register offsets, field positions and reset values for the compensation and limit bank.
// Assumes an 8-bit register address from the serial interface command byte.
`ifndef REMOTE_COMP_LIMIT_REGS_SVH
`define REMOTE_COMP_LIMIT_REGS_SVH

`define OFS_NOISE_FILTER_ENABLE      8'h18
`define OFS_BETA_COMP_ENABLE         8'h19
`define OFS_BETA_READBACK_CH1        8'h1A
`define OFS_BETA_READBACK_CH2        8'h1B
`define OFS_BETA_READBACK_CH3        8'h1C
`define OFS_LOCAL_HIGH_LIMIT_UPPER   8'h20
`define OFS_LOCAL_HIGH_LIMIT_LOWER   8'h21
`define OFS_REMOTE1_HIGH_LIMIT_UPPER 8'h22
`define OFS_REMOTE1_HIGH_LIMIT_LOWER 8'h23

`define RST_CHANNEL_ENABLE           3'h0
`define RST_BETA_READBACK            4'h0
`define RST_LIMIT_UPPER              8'h7F
`define RST_LIMIT_LOWER              4'h0

`define CH_ENABLE_LSB                1
`define CH_ENABLE_MSB                3
`define LOWER_FRAC_LSB               4

`define RESULT_CEIL_NORMAL           16'h7FF0
`define RESULT_CEIL_EXTENDED         16'hBFF0

`endif

// ===== rtl/remote_comp_limit_pkg.sv
// Types shared by the compensation and limit bank.
// Assumes the bank header is available alongside.
package remote_comp_limit_pkg;
	typedef logic [7:0]  reg_byte_t;
	typedef logic [15:0] temp_word_t;
	typedef logic [3:0]  beta_code_t;
endpackage : remote_comp_limit_pkg

// ===== test/comp_limit_props.sv
// Assertions on the register port and the noise-filter enable and ceiling outputs of the bank.
// Bound from tb_top; one clock domain, sync active-low reset.
`timescale 1ns/10ps
module comp_limit_props(
	input	wire logic		mclk,
	input	wire logic		rst_n,
	input	wire logic		reg_wr,
	input	wire logic		reg_rd,
	input	wire logic [7:0]	reg_addr,
	input	wire logic [7:0]	reg_wdata,
	input	wire logic [7:0]	reg_rdata,
	input	wire logic		reg_rvalid,
	input	wire logic		extended_range_select,
	input	wire logic [2:0]	noise_filter_on,
	input	wire logic [15:0]	temp_ceiling
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_rd(a); reg_rd && reg_addr == a; endsequence
	property p_rv; reg_rd |=> reg_rvalid; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_hi; reg_rd && reg_addr inside {[8'h18:8'h1C]} |=> reg_rdata[7:4] == 4'h0; endproperty
	a_hi: assert property (p_hi) else $error("reserved nibble set");
	property p_lo; s_rd(8'h21) or s_rd(8'h23) |=> reg_rdata[3:0] == 4'h0; endproperty
	a_lo: assert property (p_lo) else $error("limit low nibble set");
	property p_en0; s_rd(8'h18) or s_rd(8'h19) |=> !reg_rdata[0]; endproperty
	a_en0: assert property (p_en0) else $error("enable bit 0 set");
	// Output copy trails the register by one cycle, hence two edges
	property p_nf; logic [2:0] d;
		(reg_wr && reg_addr == 8'h18, d = reg_wdata[3:1]) |-> ##2 noise_filter_on == d; endproperty
	a_nf: assert property (p_nf) else $error("filter enable output wrong");
	property p_ceil; 1 |=> temp_ceiling == ($past(extended_range_select) ? 16'hBFF0 : 16'h7FF0);
	endproperty
	a_ceil: assert property (p_ceil) else $error("ceiling wrong");
	property p_wr_rd; logic [7:0] d;
		(reg_wr && reg_addr == 8'h20, d = reg_wdata) ##1 s_rd(8'h20) |=> reg_rdata == d; endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("upper limit readback wrong");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule : comp_limit_props

// ===== test/smbus_host_model.sv
// Behavioural host issuing one register access per cycle.
// Callers enter its tasks at a falling edge of mclk.
`timescale 1ns/10ps
module smbus_host_model(
	input	wire logic		mclk,
	input	wire logic [7:0]	reg_rdata,
	output	logic [7:0]		reg_addr,
	output	logic [7:0]		reg_wdata,
	output	logic			reg_wr,
	output	logic			reg_rd
);
	initial
	begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
	end
	// Limit codes go out as given; the caller picks the encoding
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, 2'b10};
		@(negedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		{reg_addr, reg_wr, reg_rd} = {a, 2'b01};
		@(negedge mclk);
		q = reg_rdata;
	endtask : rd
	// Released data is inverted so stale values cannot pass
	task automatic idle;
		{reg_wdata, reg_wr, reg_rd} = {~reg_wdata, 2'b00};
		@(negedge mclk);
	endtask : idle
endmodule : smbus_host_model

// ===== test/tb_top.sv
// Random register and compare bench for the bank, fixed seed.
// Host model owns the register strobes; bench drives the engine side.
`timescale 1ns/10ps
module tb_top;
	import remote_comp_limit_pkg::*;
	logic		mclk, rst_n, ers, rv, wr, rd, rvld, lf, rf;
	logic [7:0]	adr, wd, rdat, q, u, l;
	logic [11:0]	bcode;
	logic [2:0]	bval, nf, bc;
	logic [15:0]	lt, rt, ceil;
	int		bad_count, n_tests;
	remote_channel_comp_and_limit_regs dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(adr),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rvld),
		.extended_range_select(ers), .beta_code_in(bcode), .beta_code_valid(bval),
		.local_temp(lt), .remote1_temp(rt), .result_valid(rv), .noise_filter_on(nf),
		.beta_comp_on(bc), .temp_ceiling(ceil), .local_high_flag(lf), .remote1_high_flag(rf));
	smbus_host_model h_u (.mclk(mclk), .reg_rdata(rdat), .reg_addr(adr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd));
	function automatic logic [15:0] lw(logic [7:0] a, logic [7:0] b);
		return {a, b[7:4], 4'h0};
	endfunction : lw
	task automatic chk(logic [15:0] s, logic [15:0] e, string n);
		n_tests++;
		if (s !== e) begin bad_count++; $display("Error %s exp %h got %h", n, e, s); end
	endtask : chk
	task print_verdict;
		$display("Checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	initial begin mclk = 0; forever #12.5 mclk = ~mclk; end
	initial begin repeat (3000) @(posedge mclk); bad_count++; print_verdict(); end
	// ==========
	// Main sequence
	initial
	begin
		{rst_n, ers, rv, bcode, bval, lt, rt, bad_count, n_tests} = '0;
		void'($urandom(59429));
		repeat (4) @(negedge mclk);
		rst_n = 1;
		for (int i = 0; i < 10; i++) h_u.rd(ofs(i), q);
		for (int i = 0; i < 10; i++)
		begin
			h_u.rd(ofs(i), q);
			chk(q, (i == 5 || i == 7) ? 8'h7F : 8'h00, "reset");
		end
		repeat (3)
		begin
			u = $urandom; h_u.wr(8'h18, u); h_u.wr(8'h19, ~u); h_u.rd(8'h18, q);
			chk(q, {4'h0, u[3:1], 1'b0}, "filter");
			h_u.rd(8'h19, q);
			chk(q, {4'h0, ~u[3:1], 1'b0}, "beta en");
			chk({nf, bc}, {u[3:1], ~u[3:1]}, "enable outs");
		end
		bcode = $urandom; bval = 3'h7; @(negedge mclk); bval = 3'h0;
		for (int c = 0; c < 3; c++)
		begin
			h_u.wr(8'(8'h1A + c), 8'hFF); h_u.rd(8'(8'h1A + c), q);
			chk(q, {4'h0, bcode[4*c +: 4]}, "beta code");
			chk(rvld, 1'b1, "read valid");
		end
		repeat (20)
		begin
			u = $urandom; l = $urandom; lt = $urandom; ers = lt[1];
			if (u[0]) lt = lw(u, l) + {15'h0, u[1]};
			rt = u[2] ? lw(u, ~l) + {15'h0, u[3]} : 16'($urandom);
			h_u.wr(8'h21, l); h_u.wr(8'h22, u); h_u.wr(8'h23, ~l); h_u.wr(8'h20, u);
			h_u.rd(8'h20, q);
			chk(q, u, "upper");
			h_u.rd(8'h21, q);
			chk(q, {l[7:4], 4'h0}, "lower");
			rv = 1; h_u.idle(); rv = 0; @(negedge mclk);
			chk(lf, $signed(lt) > $signed(lw(u, l)), "local flag");
			chk(rf, $signed(rt) > $signed(lw(u, ~l)), "remote1 flag");
			chk(ceil, ers ? 16'hBFF0 : 16'h7FF0, "ceiling");
			chk(rvld, 1'b0, "read valid idle");
			ers = ~ers; h_u.rd(8'h22, q);
			chk(q, u, "kept upper");
			h_u.rd(8'h23, q);
			chk(q, {~l[7:4], 4'h0}, "kept lower");
		end
		h_u.idle();
		print_verdict();
	end
	function automatic logic [7:0] ofs(int i);
		return i < 5 ? 8'(8'h18 + i) : (i < 9 ? 8'(8'h1B + i) : 8'h40);
	endfunction : ofs
endmodule : tb_top
bind remote_channel_comp_and_limit_regs comp_limit_props chk_u (.mclk(mclk), .rst_n(rst_n),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .extended_range_select(extended_range_select),
	.noise_filter_on(noise_filter_on), .temp_ceiling(temp_ceiling));
